// >>> rtl/sdcd_top.sv
// Command decoder, bank tracker and burst engine of an eight bank DRAM
//
// Functional notes
// - Chip select high masks every command input except clock enable, which still exits power down
// - No-operation starts nothing, work continues
// - Activate opens chosen row in chosen bank
// - Row stays open until precharged
// - Precharge closes one bank or all banks
// - Precharged bank waits row precharge time
// - Repeat precharge accepted, timing restarts
// - Other bank access allowed if no overlap
// - Read/write decode, A10 requests auto precharge
// - On-the-fly A12 picks chop or eight
// - Burst starts at column, programmed order
// - Eight word prefetch, two beats per clock
// - Eight independent banks addressed by bank bits
// - Mode set, refresh, calibration decode
// - Clock enable previous and current pair
// - Self refresh and power down entry
// - Exit on rising clock enable with idle
// - Masked write beats are not stored
`timescale 1ns/1ps
`include "sdcd_map.svh"
module sdcd_top #(
    parameter int DQ_W = 16,
    parameter int TRP_CYC = `SDCD_TRP_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire sdcd_pkg::sdcd_cmd_t cmd,
    input wire logic [DQ_W/8-1:0] dm,
    input wire logic [DQ_W-1:0] dq_in_rise,
    input wire logic [DQ_W-1:0] dq_in_fall,
    output logic [DQ_W-1:0] dq_out_rise,
    output logic [DQ_W-1:0] dq_out_fall,
    output logic dq_oe_n,
    output sdcd_pkg::sdcd_core_t core,
    output logic [8*DQ_W-1:0] core_wdata,
    output logic [8*(DQ_W/8)-1:0] core_wmask,
    input wire logic [8*DQ_W-1:0] core_rdata,
    output sdcd_pkg::sdcd_evt_t evt,
    output sdcd_pkg::sdcd_pwr_t pwr_state,
    output logic [7:0] bank_open,
    output logic proto_err
);
    import sdcd_pkg::*;

    localparam int BYT = DQ_W / 8;
    localparam int TW = (TRP_CYC < 2) ? 1 : $clog2(TRP_CYC + 1);

    // ****************************************
    // State registers
    // ****************************************
    logic cke_prev_q; // Clock enable seen one cycle earlier
    sdcd_pwr_t pwr_q; // Power state
    sdcd_bst_t bst_q; // Burst engine state
    logic [1:0] cnt_q; // Clock index inside a burst
    logic [1:0] last_q; // Last clock index of the burst
    logic ap_q; // Auto precharge requested for running burst
    logic [12:0] mr0_q; // Mode register zero copy
    sdcd_core_t core_q; // Registered core request
    sdcd_evt_t evt_q; // Registered side events
    logic err_q; // Protocol error pulse
    logic [7:0][DQ_W-1:0] rd_word_q; // Fetched prefetch word
    logic [7:0][DQ_W-1:0] wbuf_q; // Write assembly buffer
    logic [7:0][BYT-1:0] wmask_q; // Per word byte masks
    logic [DQ_W-1:0] dq_r_q; // Rising beat out
    logic [DQ_W-1:0] dq_f_q; // Falling beat out
    logic oe_n_q; // Data drive enable, low while driving

    // ****************************************
    // Command decode
    // ****************************************
    wire cmd_sel = ~cmd.cs_n;
    wire pwr_on = (pwr_q == SDCD_PWR_ON);
    wire cmd_live = cmd_sel & cke_prev_q & cmd.cke & pwr_on;
    wire [2:0] strb = {cmd.ras_n, cmd.cas_n, cmd.we_n};
    wire dec_act = cmd_live & (strb == 3'h3);
    wire dec_pre = cmd_live & (strb == 3'h2);
    wire dec_wr = cmd_live & (strb == 3'h4);
    wire dec_rd = cmd_live & (strb == 3'h5);
    wire dec_mrs = cmd_live & (strb == 3'h0);
    wire dec_ref = cmd_live & (strb == 3'h1);
    wire dec_zq = cmd_live & (strb == 3'h6);
    wire dec_nop = cmd_live & (strb == 3'h7);

    // ****************************************
    // Bank status views
    // ****************************************
    wire [7:0] act_w; // Bank holds an open row
    wire [7:0] trp_w; // Bank still inside precharge time
    wire [12:0] row_w [8]; // Open row per bank
    wire bst_idle = (bst_q == SDCD_BST_IDLE);
    wire all_quiet = ~|act_w & ~|trp_w & bst_idle & ~core_q.wr;
    wire bank_act = act_w[cmd.ba];
    wire bank_trp = trp_w[cmd.ba];

    // ****************************************
    // Legality checks
    // ****************************************
    wire bad_act = dec_act & (bank_act | bank_trp);
    wire bad_rw = (dec_rd | dec_wr) & (~bank_act | ~bst_idle);
    wire bad_idle = (dec_mrs | dec_ref | dec_zq) & ~all_quiet;
    wire good_act = dec_act & ~bad_act;
    wire good_pre = dec_pre;
    wire good_rd = dec_rd & ~bad_rw;
    wire good_wr = dec_wr & ~bad_rw;

    // ****************************************
    // Power state decode
    // ****************************************
    wire cke_fall = cke_prev_q & ~cmd.cke;
    wire cke_rise = ~cke_prev_q & cmd.cke;
    wire ent_ok = pwr_on & cke_fall & cmd_sel & all_quiet;
    wire ent_sr = ent_ok & (strb == 3'h1);
    wire ent_pd = ent_ok & (strb == 3'h7);
    wire exit_ok = ~pwr_on & cke_rise & (cmd.cs_n | (strb == 3'h7));
    wire exit_bad = ~pwr_on & cke_rise & ~exit_ok;

    // ****************************************
    // Burst length and ordering
    // ****************************************
    wire [1:0] bl_mode = mr0_q[`SDCD_MR0_BL_LSB +: 2];
    wire bc4_sel = (bl_mode == `SDCD_BL_FIXED4)
        | ((bl_mode == `SDCD_BL_OTF) & ~cmd.addr[`SDCD_BC_BIT]);
    wire [1:0] last_sel = bc4_sel ? `SDCD_CLK_BC4 : `SDCD_CLK_BL8;
    wire [7:0][2:0] word_idx; // Word for each beat
    wire [2:0] beat_r = {cnt_q, 1'b0};
    wire [2:0] beat_f = {cnt_q, 1'b1};
    wire [2:0] widx_r = word_idx[beat_r];
    wire [2:0] widx_f = word_idx[beat_f];
    wire burst_end = (cnt_q == last_q);
    wire ap_close = ap_q & ((bst_q == SDCD_BST_RD) & burst_end | (bst_q == SDCD_BST_WCOM));

    // Start column selects the first word, mode bit picks the order
    sdcd_order u_order (
        .start(core_q.col[2:0]),
        .interleave(mr0_q[`SDCD_MR0_BT_BIT]),
        .word_idx(word_idx)
    );

    // ****************************************
    // Per bank state
    // ****************************************
    genvar gb;
    generate
        for (gb = 0; gb < 8; gb++) begin : g_bank
            logic act_b_q;
            logic [12:0] row_b_q;
            logic [TW-1:0] trp_b_q;
            wire hit_b = (cmd.ba == 3'(gb));
            wire close_b = (good_pre & (cmd.addr[`SDCD_AP_BIT] | hit_b))
                | (ap_close & (core_q.bank == 3'(gb)));
            wire open_b = good_act & hit_b;
            // Open on activate, close and restart precharge time on precharge
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    act_b_q <= 1'b0;
                    row_b_q <= 13'h0000;
                    trp_b_q <= '0;
                end else if (close_b) begin
                    act_b_q <= 1'b0;
                    trp_b_q <= TW'(TRP_CYC);
                end else if (open_b) begin
                    act_b_q <= 1'b1;
                    row_b_q <= cmd.addr;
                end else if (trp_b_q != '0) begin
                    trp_b_q <= trp_b_q - 1'b1;
                end
            end
            assign act_w[gb] = act_b_q;
            assign trp_w[gb] = (trp_b_q != '0);
            assign row_w[gb] = row_b_q;
        end
    endgenerate

    // ****************************************
    // Clock enable history and power state
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cke_prev_q <= 1'b0;
            pwr_q <= SDCD_PWR_ON;
        end else begin
            cke_prev_q <= cmd.cke;
            unique case (pwr_q)
                SDCD_PWR_ON: begin
                    if (ent_sr) begin
                        pwr_q <= SDCD_PWR_SR;
                    end else if (ent_pd) begin
                        pwr_q <= SDCD_PWR_PD;
                    end
                end
                SDCD_PWR_PD, SDCD_PWR_SR: begin
                    if (exit_ok) begin
                        pwr_q <= SDCD_PWR_ON;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Burst engine
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bst_q <= SDCD_BST_IDLE;
            cnt_q <= 2'h0;
            last_q <= 2'h0;
            ap_q <= 1'b0;
            core_q <= '0;
        end else begin
            core_q.rd <= 1'b0;
            core_q.wr <= 1'b0;
            unique case (bst_q)
                SDCD_BST_IDLE: begin
                    // Latch address and length of a new access
                    if (good_rd | good_wr) begin
                        bst_q <= good_rd ? SDCD_BST_RFETCH : SDCD_BST_WR;
                        core_q.rd <= good_rd;
                        core_q.bank <= cmd.ba;
                        core_q.row <= row_w[cmd.ba];
                        core_q.col <= cmd.addr[9:0];
                        ap_q <= cmd.addr[`SDCD_AP_BIT];
                        last_q <= last_sel;
                        cnt_q <= 2'h0;
                    end
                end
                SDCD_BST_RFETCH: begin
                    bst_q <= SDCD_BST_RD;
                end
                SDCD_BST_RD, SDCD_BST_WR: begin
                    cnt_q <= cnt_q + 2'h1;
                    if (burst_end) begin
                        bst_q <= (bst_q == SDCD_BST_RD) ? SDCD_BST_IDLE : SDCD_BST_WCOM;
                    end
                end
                SDCD_BST_WCOM: begin
                    core_q.wr <= 1'b1;
                    bst_q <= SDCD_BST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Read data path
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_word_q <= '0;
            dq_r_q <= '0;
            dq_f_q <= '0;
            oe_n_q <= 1'b1;
        end else begin
            if (bst_q == SDCD_BST_RFETCH) begin
                rd_word_q <= core_rdata;
            end
            oe_n_q <= ~(bst_q == SDCD_BST_RD);
            if (bst_q == SDCD_BST_RD) begin
                dq_r_q <= rd_word_q[widx_r];
                dq_f_q <= rd_word_q[widx_f];
            end
        end
    end

    // ****************************************
    // Write assembly, one slot per word
    // ****************************************
    wire wr_beat = (bst_q == SDCD_BST_WR);
    genvar gw;
    generate
        for (gw = 0; gw < 8; gw++) begin : g_word
            wire hit_r = wr_beat & (widx_r == 3'(gw));
            wire hit_f = wr_beat & (widx_f == 3'(gw));
            // Unvisited words stay masked so a chopped burst leaves them alone
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    wbuf_q[gw] <= '0;
                    wmask_q[gw] <= '1;
                end else if ((bst_q == SDCD_BST_IDLE) & good_wr) begin
                    wmask_q[gw] <= '1;
                end else if (hit_r) begin
                    wbuf_q[gw] <= dq_in_rise;
                    wmask_q[gw] <= dm;
                end else if (hit_f) begin
                    wbuf_q[gw] <= dq_in_fall;
                    wmask_q[gw] <= dm;
                end
            end
        end
    endgenerate

    // ****************************************
    // Mode register, side events, errors
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mr0_q <= `SDCD_MR0_RST;
            evt_q <= '0;
            err_q <= 1'b0;
        end else begin
            evt_q.ref_p <= dec_ref & all_quiet;
            evt_q.zq_p <= dec_zq & all_quiet;
            evt_q.mrs_p <= dec_mrs & all_quiet;
            err_q <= bad_act | bad_rw | bad_idle | exit_bad;
            if (dec_zq & all_quiet) begin
                evt_q.zq_long <= cmd.addr[`SDCD_AP_BIT];
            end
            if (dec_mrs & all_quiet) begin
                evt_q.mrs_sel <= cmd.ba;
                evt_q.mrs_op <= cmd.addr;
                if (cmd.ba == `SDCD_MR_SEL0) begin
                    mr0_q <= cmd.addr;
                end
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign dq_out_rise = dq_r_q;
    assign dq_out_fall = dq_f_q;
    assign dq_oe_n = oe_n_q;
    assign core = core_q;
    assign core_wdata = wbuf_q;
    assign core_wmask = wmask_q;
    assign evt = evt_q;
    assign pwr_state = pwr_q;
    assign bank_open = act_w;
    assign proto_err = err_q;

    // ****************************************
    // Assertions
    // ****************************************
    AST_DESEL_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
        cmd.cs_n |=> !core.rd) else $error("deselect started a read");
    AST_NOP_STABLE: assert property (@(posedge sys_clk) disable iff (rst)
        (dec_nop && !ap_close) |=> $stable(bank_open)) else $error("nop changed banks");
    AST_ACT_OPEN: assert property (@(posedge sys_clk) disable iff (rst)
        good_act |=> bank_open[$past(cmd.ba)]) else $error("activate did not open bank");
    AST_PRE_ALL: assert property (@(posedge sys_clk) disable iff (rst)
        (good_pre && cmd.addr[`SDCD_AP_BIT]) |=> (bank_open == 8'h00))
        else $error("precharge all left a bank open");
    AST_ACT_EARLY: assert property (@(posedge sys_clk) disable iff (rst)
        (dec_act && trp_w[cmd.ba]) |=> (proto_err && !bank_open[$past(cmd.ba)]))
        else $error("activate inside precharge time accepted");
    AST_RD_BL8: assert property (@(posedge sys_clk) disable iff (rst)
        (good_rd && !bc4_sel) |-> ##3 !dq_oe_n [*4] ##1 dq_oe_n)
        else $error("read burst of eight wrong length");
    AST_RD_BC4: assert property (@(posedge sys_clk) disable iff (rst)
        (good_rd && bc4_sel) |-> ##3 !dq_oe_n [*2] ##1 dq_oe_n)
        else $error("chopped read wrong length");
    AST_WR_COMMIT: assert property (@(posedge sys_clk) disable iff (rst)
        (good_wr && !bc4_sel) |-> ##6 core.wr) else $error("write not committed");
    AST_RW_IDLE_ERR: assert property (@(posedge sys_clk) disable iff (rst)
        ((dec_rd || dec_wr) && !bank_act) |=> (proto_err && !core.rd))
        else $error("access to idle bank not flagged");
    AST_SR_ENTRY: assert property (@(posedge sys_clk) disable iff (rst)
        ent_sr |=> (pwr_state == SDCD_PWR_SR)) else $error("self refresh not entered");
    AST_PD_EXIT: assert property (@(posedge sys_clk) disable iff (rst)
        exit_ok |=> (pwr_state == SDCD_PWR_ON)) else $error("power state not left");
    AST_CKE_LOW: assert property (@(posedge sys_clk) disable iff (rst)
        !cke_prev_q |=> (!core.rd && !evt.ref_p)) else $error("command taken with cke low");
endmodule

// >>> rtl/sdcd_map.svh
// Constants for the DRAM command decoder: timing, bit positions, fields
`ifndef SDCD_MAP_SVH
`define SDCD_MAP_SVH
// ****************************************
// Clock and timing
// ****************************************
`define SDCD_CLK_MHZ 40
`define SDCD_TRP_NS 15
`define SDCD_TRP_CYC (((`SDCD_TRP_NS * `SDCD_CLK_MHZ) + 999) / 1000)
// ****************************************
// Address bit positions
// ****************************************
`define SDCD_AP_BIT 10
`define SDCD_BC_BIT 12
// ****************************************
// Mode register zero fields
// ****************************************
`define SDCD_MR0_BL_LSB 0
`define SDCD_MR0_BT_BIT 3
`define SDCD_BL_FIXED8 2'h0
`define SDCD_BL_OTF 2'h1
`define SDCD_BL_FIXED4 2'h2
`define SDCD_MR0_RST 13'h0000
`define SDCD_MR_SEL0 3'h0
// ****************************************
// Burst geometry in clocks
// ****************************************
`define SDCD_CLK_BL8 2'h3
`define SDCD_CLK_BC4 2'h1
`endif

// >>> rtl/sdcd_pkg.sv
// Types shared by the DRAM command decoder modules
package sdcd_pkg;
    // Command pins sampled on each rising clock
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic cke;
        logic [2:0] ba;
        logic [12:0] addr;
    } sdcd_cmd_t;
    // Core array access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] bank;
        logic [12:0] row;
        logic [9:0] col;
    } sdcd_core_t;
    // Side events reported to the array model
    typedef struct packed {
        logic ref_p;
        logic zq_p;
        logic zq_long;
        logic mrs_p;
        logic [2:0] mrs_sel;
        logic [12:0] mrs_op;
    } sdcd_evt_t;
    // Power states
    typedef enum logic [2:0] {
        SDCD_PWR_ON = 3'b001,
        SDCD_PWR_PD = 3'b010,
        SDCD_PWR_SR = 3'b100
    } sdcd_pwr_t;
    // Burst engine states
    typedef enum logic [4:0] {
        SDCD_BST_IDLE = 5'b00001,
        SDCD_BST_RFETCH = 5'b00010,
        SDCD_BST_RD = 5'b00100,
        SDCD_BST_WR = 5'b01000,
        SDCD_BST_WCOM = 5'b10000
    } sdcd_bst_t;
endpackage

// >>> rtl/sdcd_order.sv
// Beat to word ordering inside one eight word prefetch
`timescale 1ns/1ps
module sdcd_order (
    input wire logic [2:0] start,
    input wire logic interleave,
    output logic [7:0][2:0] word_idx
);
    // ****************************************
    // One ordering term per beat
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_beat
            // Sequential wraps within each half, interleaved xors the index
            assign word_idx[gi] = interleave ? (start ^ 3'(gi))
                : {start[2] ^ 1'(gi >> 2), 2'(start[1:0] + 2'(gi))};
        end
    endgenerate
endmodule

// >>> tb/sdcd_ctrl_model.sv
// Controller-side model: drives command pins, write beats and the array read port
`timescale 1ns/1ps
module sdcd_ctrl_model (
    input wire logic sys_clk,
    output sdcd_pkg::sdcd_cmd_t cmd,
    output logic [1:0] dm,
    output logic [15:0] dq_in_rise,
    output logic [15:0] dq_in_fall,
    input wire sdcd_pkg::sdcd_core_t core,
    output logic [127:0] core_rdata
);
    import sdcd_pkg::*;
    // ****************************************
    // Array answer
    // ****************************************
    // Word w of the selected bank carries bank and word index, so order is visible
    for (genvar w = 0; w < 8; w++) begin : g_rd
        assign core_rdata[16*w+:16] = {4'ha, 1'b0, core.bank, 5'h0, 3'(w)};
    end
    // Quiet start: no-operation with clock enable high
    initial begin
        cmd = {4'h7, 1'b1, 3'h0, 13'h0000};
        dm = 2'h3;
        dq_in_rise = 16'h0000;
        dq_in_fall = ~dq_in_rise;
    end
    // ****************************************
    // Command tasks
    // ****************************************
    // One command cycle; strobes are {cs_n, ras_n, cas_n, we_n}
    task automatic cyc(input logic [3:0] s, input logic ck, input logic [2:0] ba,
                       input logic [12:0] a, input logic [31:0] d, input logic [1:0] m);
        @(posedge sys_clk);
        cmd <= {s, ck, ba, a};
        dq_in_rise <= d[15:0];
        dq_in_fall <= d[31:16];
        dm <= m;
    endtask
    // Filler cycle; released data lines show the inverse of their last value
    task automatic nop(input logic ck);
        cyc(4'h7, ck, 3'h0, 13'h0000, ~{dq_in_fall, dq_in_rise}, 2'h3);
    endtask
    // Command, one filler, then settle just past the sampling edge
    task automatic go(input logic [3:0] s, input logic [2:0] ba, input logic [12:0] a);
        cyc(s, 1'b1, ba, a, ~{dq_in_fall, dq_in_rise}, 2'h3);
        nop(1'b1);
        #1;
    endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench of the DRAM command decoder
`timescale 1ns/1ps
module tb;
    import sdcd_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    localparam logic [3:0] NOP = 4'h7, DES = 4'hf, ACT = 4'h3, PRE = 4'h2, RD = 4'h5;
    localparam logic [3:0] WR = 4'h4, MRS = 4'h0, REF = 4'h1, ZQ = 4'h6, DACT = 4'hb;
    logic sys_clk;
    logic rst;
    sdcd_cmd_t cmd;
    logic [1:0] dm;
    logic [15:0] dq_in_rise, dq_in_fall, dq_out_rise, dq_out_fall;
    logic dq_oe_n, proto_err;
    sdcd_core_t core;
    logic [127:0] core_wdata, core_rdata;
    logic [15:0] core_wmask;
    sdcd_evt_t evt;
    sdcd_pwr_t pwr_state;
    logic [7:0] bank_open;
    int n_fail = 0;
    int n_tests = 0;
    // Clock at 40 MHz
    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;
    sdcd_ctrl_model ctl (.sys_clk(sys_clk), .cmd(cmd), .dm(dm), .dq_in_rise(dq_in_rise),
        .dq_in_fall(dq_in_fall), .core(core), .core_rdata(core_rdata));
    sdcd_top uut (.sys_clk(sys_clk), .rst(rst), .cmd(cmd), .dm(dm),
        .dq_in_rise(dq_in_rise), .dq_in_fall(dq_in_fall), .dq_out_rise(dq_out_rise),
        .dq_out_fall(dq_out_fall), .dq_oe_n(dq_oe_n), .core(core), .core_wdata(core_wdata),
        .core_wmask(core_wmask), .core_rdata(core_rdata), .evt(evt), .pwr_state(pwr_state),
        .bank_open(bank_open), .proto_err(proto_err));
    // ****************************************
    // Helpers
    // ****************************************
    // Compare and count
    task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Verdict and end of run
    task automatic print_verdict;
        if (n_fail == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    // Outputs after reset
    task automatic t_reset;
        chk("pwr", SDCD_PWR_ON, pwr_state);
        chk("open", 8'h00, bank_open);
        chk("oe_n", 1'b1, dq_oe_n);
        chk("wmask", 16'hffff, core_wmask);
    endtask
    // Mode registers in order 2,3,1,0, then long calibration
    task automatic t_init;
        logic [2:0] sel [4] = '{3'h2, 3'h3, 3'h1, 3'h0};
        for (int i = 0; i < 4; i++) begin
            ctl.go(MRS, sel[i], (i == 3) ? 13'h0001 : 13'h0000);
            chk("mrs_p", 1'b1, evt.mrs_p);
            chk("mrs_sel", {sel[i], 13'(i == 3)}, {evt.mrs_sel, evt.mrs_op});
        end
        ctl.go(ZQ, 3'h0, 13'h0400);
        chk("zq_long", 2'h3, {evt.zq_p, evt.zq_long});
    endtask
    // Open, deselect, refuse, close single and all
    task automatic t_bank;
        ctl.go(ACT, 3'h3, 13'h0123);
        chk("act3", 9'h008, {proto_err, bank_open});
        ctl.go(DACT, 3'h5, 13'h0000);
        chk("deselect", 9'h008, {proto_err, bank_open});
        ctl.go(ACT, 3'h3, 13'h0044);
        chk("act open", 9'h108, {proto_err, bank_open});
        ctl.go(ACT, 3'h5, 13'h0001);
        ctl.go(PRE, 3'h3, 13'h0000);
        chk("pre one", 9'h020, {proto_err, bank_open});
        ctl.go(PRE, 3'h3, 13'h0000);
        chk("pre idle", 9'h020, {proto_err, bank_open});
        // Activate right behind a precharge lands inside the precharge time
        ctl.cyc(PRE, 1'b1, 3'h3, 13'h0000, 32'h0, 2'h3);
        ctl.cyc(ACT, 1'b1, 3'h3, 13'h0009, 32'h0, 2'h3);
        ctl.nop(1'b1);
        #1;
        chk("act in trp", 9'h120, {proto_err, bank_open});
        ctl.go(PRE, 3'h0, 13'h0400);
        chk("pre all", 9'h000, {proto_err, bank_open});
    endtask
    // On-the-fly eight-beat read from column 5 with auto precharge
    task automatic t_read;
        logic [2:0] w;
        ctl.go(ACT, 3'h1, 13'h0007);
        ctl.go(RD, 3'h1, 13'h1405);
        chk("rd", {1'b1, 3'h1, 10'h005}, {core.rd, core.bank, core.col});
        for (int i = 0; i < 4 && dq_oe_n !== 1'b0; i++) begin
            @(posedge sys_clk);
            #1;
        end
        for (int k = 0; k < 4; k++) begin
            w = {1'b1 ^ k[1], 2'(1 + 2 * k)};
            chk("beat rise", {8'ha1, 5'h0, w}, dq_out_rise);
            w = {1'b1 ^ k[1], 2'(2 + 2 * k)};
            chk("beat fall", {8'ha1, 5'h0, w}, dq_out_fall);
            chk("oe_n", 1'b0, dq_oe_n);
            @(posedge sys_clk);
            #1;
        end
        chk("auto pre", 2'h2, {dq_oe_n, bank_open[1]});
        ctl.go(RD, 3'h1, 13'h0000);
        chk("rd closed", 1'b1, proto_err);
    endtask
    // Chopped write with the lower byte of the second pair masked
    task automatic t_write;
        ctl.go(ACT, 3'h2, 13'h0002);
        ctl.cyc(WR, 1'b1, 3'h2, 13'h0000, 32'h0, 2'h3);
        ctl.cyc(NOP, 1'b1, 3'h0, 13'h0000, {16'h5001, 16'h5000}, 2'h0);
        ctl.cyc(NOP, 1'b1, 3'h0, 13'h0000, {16'h5003, 16'h5002}, 2'h1);
        for (int i = 0; i < 6 && core.wr !== 1'b1; i++) begin
            ctl.nop(1'b1);
            #1;
        end
        chk("wr", 4'ha, {core.wr, core.bank});
        chk("wdata", 64'h5003_5002_5001_5000, core_wdata[63:0]);
        chk("wmask", 16'hff50, core_wmask);
        ctl.go(PRE, 3'h0, 13'h0400);
    endtask
    // Refresh, short calibration, self refresh and power down
    task automatic t_power;
        ctl.go(REF, 3'h0, 13'h0000);
        chk("ref", 1'b1, evt.ref_p);
        ctl.go(ZQ, 3'h0, 13'h0000);
        chk("zq short", 2'h2, {evt.zq_p, evt.zq_long});
        ctl.cyc(REF, 1'b0, 3'h0, 13'h0000, 32'h0, 2'h3);
        ctl.nop(1'b0);
        #1;
        chk("sr entry", SDCD_PWR_SR, pwr_state);
        ctl.cyc(DES, 1'b1, 3'h0, 13'h0000, 32'h0, 2'h3);
        ctl.nop(1'b1);
        #1;
        chk("sr exit", SDCD_PWR_ON, pwr_state);
        ctl.nop(1'b1);
        ctl.cyc(NOP, 1'b0, 3'h0, 13'h0000, 32'h0, 2'h3);
        ctl.nop(1'b0);
        #1;
        chk("pd entry", SDCD_PWR_PD, pwr_state);
        ctl.cyc(NOP, 1'b1, 3'h0, 13'h0000, 32'h0, 2'h3);
        ctl.nop(1'b1);
        #1;
        chk("pd exit", SDCD_PWR_ON, pwr_state);
        // Power down again, then a refresh code with rising enable is refused
        ctl.cyc(NOP, 1'b0, 3'h0, 13'h0000, 32'h0, 2'h3);
        ctl.cyc(REF, 1'b1, 3'h0, 13'h0000, 32'h0, 2'h3);
        ctl.nop(1'b0);
        #1;
        chk("bad exit", 4'ha, {proto_err, pwr_state});
        ctl.cyc(DES, 1'b1, 3'h0, 13'h0000, 32'h0, 2'h3);
        ctl.nop(1'b1);
        #1;
        chk("des exit", SDCD_PWR_ON, pwr_state);
    endtask
    // Fixed chop of four in interleaved order, whatever A12 says
    task automatic t_mode;
        ctl.go(MRS, 3'h0, 13'h000a);
        ctl.go(ACT, 3'h4, 13'h0010);
        ctl.go(RD, 3'h4, 13'h1003);
        chk("rd row", {1'b1, 13'h0010}, {core.rd, core.row});
        for (int i = 0; i < 4 && dq_oe_n !== 1'b0; i++) begin
            @(posedge sys_clk);
            #1;
        end
        for (int k = 0; k < 2; k++) begin
            chk("ilv rise", {8'ha4, 5'h0, 3'(3 ^ (2 * k))}, dq_out_rise);
            chk("ilv fall", {8'ha4, 5'h0, 3'(3 ^ (2 * k + 1))}, dq_out_fall);
            @(posedge sys_clk);
            #1;
        end
        chk("bc4 end", 2'h3, {dq_oe_n, bank_open[4]});
        ctl.go(PRE, 3'h0, 13'h0400);
    endtask
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        rst = 1'b1;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        ctl.nop(1'b1);
        ctl.nop(1'b1);
        #1;
        t_reset;
        t_init;
        t_bank;
        t_read;
        t_write;
        t_power;
        t_mode;
        print_verdict;
    end
    // Run is about 90 cycles; cut off far beyond
    initial begin
        #(25 * 5000);
        n_fail++;
        print_verdict;
    end
endmodule
